// >>> pkg/crs_pkg.sv
// package for the return, rotate, subtract and sleep execution block
package crs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_INSTR     = 8'h00;
  localparam logic [7:0] ADDR_WREG      = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_PROG_CTR  = 8'h0C;
  localparam logic [7:0] ADDR_STACK     = 8'h10;
  localparam logic [7:0] ADDR_FILE_ADDR = 8'h14;
  localparam logic [7:0] ADDR_FILE_DATA = 8'h18;
  localparam logic [7:0] ADDR_WATCHDOG  = 8'h1C;
  localparam logic [7:0] ADDR_WAKE      = 8'h20;
  // instruction word fields
  localparam int INSTR_K_LSB   = 0;
  localparam int INSTR_D_BIT   = 8;
  localparam int INSTR_OP_LSB  = 9;
  // status bit positions
  localparam int ST_C        = 0;
  localparam int ST_DIG_C    = 1;
  localparam int ST_Z        = 2;
  localparam int ST_PWR_DN   = 3;
  localparam int ST_TIME_OUT = 4;
  localparam int ST_BUSY     = 5;
  localparam int ST_SLEEP    = 6;
  // reset values
  localparam logic [7:0]  WREG_RST     = 8'h00;
  localparam logic [12:0] PROG_CTR_RST = 13'h0000;
  localparam logic [7:0]  WATCHDOG_CLR = 8'h00;
  // answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operation codes
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_RETLIT   = 3'b001,
    OP_ROT_L    = 3'b010,
    OP_ROT_R    = 3'b011,
    OP_SUB_LIT  = 3'b100,
    OP_SUB_REG  = 3'b101,
    OP_SLEEP    = 3'b110
  } crs_op_type;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RET2   = 2'b01,
    ST_ASLEEP = 2'b10
  } crs_state_type;
endpackage

// >>> verilog/crs_core_exec.sv
// execution datapath for return-with-literal, rotates, subtracts and sleep
`timescale 1ns/100ps
module crs_core_exec
  import crs_pkg::*;
#(
  parameter int FILE_DEPTH  = 128,
  parameter int STACK_DEPTH = 16,
  parameter int PRE_WIDTH   = 8
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // power control
  output logic             osc_stop
);
  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int FA_W = $clog2(FILE_DEPTH);

  // returns {carry, digit_carry, difference}; carry set means no borrow
  function automatic logic [9:0] sub_flags(input logic [7:0] minu, input logic [7:0] subt);
    logic [7:0] diff;
    diff = minu - subt;
    return {minu >= subt, minu[3:0] >= subt[3:0], diff};
  endfunction

  crs_state_type state_ff;
  logic [7:0]  wreg_ff;
  logic [12:0] program_counter_ff;
  logic [12:0] ret_addr_ff;
  logic [12:0] stack_ff [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [7:0]  file_ff [FILE_DEPTH];
  logic [FA_W-1:0] file_addr_ff;
  logic        carry_ff, digit_carry_flag_ff, zero_ff;
  logic        power_down_flag_ff, timeout_flag_ff;
  logic [7:0]  watchdog_counter_ff;
  logic [PRE_WIDTH-1:0] prescaler_ff;
  logic [7:0]  aw_addr_ff, ar_addr_ff;
  logic [31:0] w_data_ff;
  logic        aw_full_ff, w_full_ff;

  // write channels are latched separately so address and data may come in either order
  assign s_axi_awready = !aw_full_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  logic wr_go;
  logic wr_hit;
  logic all_lanes;
  assign wr_go     = aw_full_ff && w_full_ff;
  assign all_lanes = &s_axi_wstrb;
  assign wr_hit    = (aw_addr_ff <= ADDR_WAKE) && (aw_addr_ff[1:0] == 2'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_ff <= 1'b0;
    end
  end

  logic [3:0] w_strb_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // strobes: a byte lane write of the low byte is enough for every register
  logic wr_low;
  assign wr_low = wr_go && w_strb_ff[0];
  logic issue, sleeping;
  assign sleeping = (state_ff == ST_ASLEEP);
  // instructions are refused while a return finishes or the core sleeps
  assign issue = wr_low && aw_addr_ff == ADDR_INSTR && state_ff == ST_IDLE;

  crs_op_type op;
  logic [7:0] lit;
  logic       dest;
  assign op   = crs_op_type'(w_data_ff[INSTR_OP_LSB +: 3]);
  assign lit  = w_data_ff[INSTR_K_LSB +: 8];
  assign dest = w_data_ff[INSTR_D_BIT];

  logic [FA_W-1:0] f_idx;
  logic [7:0]      f_val;
  logic [9:0]      sub_lit, sub_reg;
  logic [7:0]      rot_l, rot_r;
  assign f_idx   = lit[FA_W-1:0];
  assign f_val   = file_ff[f_idx];
  assign sub_lit = sub_flags(lit, wreg_ff);
  assign sub_reg = sub_flags(f_val, wreg_ff);
  assign rot_l   = {f_val[6:0], carry_ff};
  assign rot_r   = {carry_ff, f_val[7:1]};

  logic [7:0] result;
  logic       res_valid;
  always_comb begin
    result    = 8'h00;
    res_valid = 1'b0;
    case (op)
      OP_ROT_L: begin
        result    = rot_l;
        res_valid = 1'b1;
      end
      OP_ROT_R: begin
        result    = rot_r;
        res_valid = 1'b1;
      end
      OP_SUB_REG: begin
        result    = sub_reg[7:0];
        res_valid = 1'b1;
      end
      default: begin
        result    = 8'h00;
        res_valid = 1'b0;
      end
    endcase
  end

  // sequencing: return takes a second cycle to load the program counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      ret_addr_ff <= PROG_CTR_RST;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (issue && op == OP_RETLIT) begin
            state_ff    <= ST_RET2;
            ret_addr_ff <= stack_ff[sp_ff - SP_W'(1)];
          end else if (issue && op == OP_SLEEP) begin
            state_ff <= ST_ASLEEP;
          end
        end
        ST_RET2: state_ff <= ST_IDLE;
        ST_ASLEEP: begin
          if (wr_low && aw_addr_ff == ADDR_WAKE && w_data_ff[0]) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign osc_stop = sleeping;

  // return stack: circular, software pushes through the stack register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_ff[i] <= PROG_CTR_RST;
    end else if (issue && op == OP_RETLIT) begin
      sp_ff <= sp_ff - SP_W'(1);
    end else if (wr_low && aw_addr_ff == ADDR_STACK && state_ff == ST_IDLE) begin
      stack_ff[sp_ff] <= w_data_ff[12:0];
      sp_ff           <= sp_ff + SP_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter_ff <= PROG_CTR_RST;
    end else if (state_ff == ST_RET2) begin
      program_counter_ff <= ret_addr_ff;
    end else if (wr_low && aw_addr_ff == ADDR_PROG_CTR && state_ff == ST_IDLE) begin
      program_counter_ff <= w_data_ff[12:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wreg_ff <= WREG_RST;
    end else if (issue && op == OP_RETLIT) begin
      wreg_ff <= lit;
    end else if (issue && op == OP_SUB_LIT) begin
      wreg_ff <= sub_lit[7:0];
    end else if (issue && res_valid && !dest) begin
      wreg_ff <= result;
    end else if (wr_low && aw_addr_ff == ADDR_WREG && !sleeping) begin
      wreg_ff <= w_data_ff[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_addr_ff <= '0;
      for (int i = 0; i < FILE_DEPTH; i++) file_ff[i] <= 8'h00;
    end else if (issue && res_valid && dest) begin
      file_ff[f_idx] <= result;
    end else if (wr_low && aw_addr_ff == ADDR_FILE_ADDR) begin
      file_addr_ff <= w_data_ff[FA_W-1:0];
    end else if (wr_low && aw_addr_ff == ADDR_FILE_DATA && !sleeping) begin
      file_ff[file_addr_ff] <= w_data_ff[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_ff            <= 1'b0;
      digit_carry_flag_ff <= 1'b0;
      zero_ff             <= 1'b0;
    end else if (issue && op == OP_ROT_L) begin
      carry_ff <= f_val[7];
    end else if (issue && op == OP_ROT_R) begin
      carry_ff <= f_val[0];
    end else if (issue && (op == OP_SUB_LIT || op == OP_SUB_REG)) begin
      carry_ff            <= (op == OP_SUB_LIT) ? sub_lit[9] : sub_reg[9];
      digit_carry_flag_ff <= (op == OP_SUB_LIT) ? sub_lit[8] : sub_reg[8];
      zero_ff             <= (op == OP_SUB_LIT) ? (sub_lit[7:0] == 8'h00)
                                                : (sub_reg[7:0] == 8'h00);
    end else if (wr_low && aw_addr_ff == ADDR_STATUS && !sleeping) begin
      carry_ff            <= w_data_ff[ST_C];
      digit_carry_flag_ff <= w_data_ff[ST_DIG_C];
      zero_ff             <= w_data_ff[ST_Z];
    end
  end

  // both flags are active low status bits and read 1 after power-on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down_flag_ff <= 1'b1;
      timeout_flag_ff    <= 1'b1;
    end else if (issue && op == OP_SLEEP) begin
      power_down_flag_ff <= 1'b0;
      timeout_flag_ff    <= 1'b1;
    end
  end

  // watchdog keeps running in sleep; it has its own clock in a real part
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_ff        <= '0;
      watchdog_counter_ff <= WATCHDOG_CLR;
    end else if (issue && op == OP_SLEEP) begin
      prescaler_ff        <= '0;
      watchdog_counter_ff <= WATCHDOG_CLR;
    end else begin
      prescaler_ff <= prescaler_ff + PRE_WIDTH'(1);
      if (&prescaler_ff) watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
    end
  end

  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (ar_addr_ff)
      ADDR_INSTR:     rd_word = 32'h0000_0000;
      ADDR_WREG:      rd_word = {24'h00_0000, wreg_ff};
      ADDR_STATUS:    rd_word = {25'h000_0000, sleeping, state_ff == ST_RET2, timeout_flag_ff,
                                 power_down_flag_ff, zero_ff, digit_carry_flag_ff, carry_ff};
      ADDR_PROG_CTR:  rd_word = {19'h0_0000, program_counter_ff};
      ADDR_STACK:     rd_word = {11'h000, 8'(sp_ff), stack_ff[sp_ff - SP_W'(1)]};
      ADDR_FILE_ADDR: rd_word = {24'h00_0000, 8'(file_addr_ff)};
      ADDR_FILE_DATA: rd_word = {24'h00_0000, file_ff[file_addr_ff]};
      ADDR_WATCHDOG:  rd_word = {16'h0000, 8'(prescaler_ff), watchdog_counter_ff};
      ADDR_WAKE:      rd_word = 32'h0000_0000;
      default:        rd_hit  = 1'b0;
    endcase
  end

  // address is captured first so read data reflects state one cycle after the request
  logic ar_pend_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ar_pend_ff   <= 1'b0;
      ar_addr_ff   <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready && !ar_pend_ff) begin
      ar_pend_ff <= 1'b1;
      ar_addr_ff <= s_axi_araddr;
    end else if (ar_pend_ff) begin
      ar_pend_ff   <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic unused_lanes;
  assign unused_lanes = all_lanes;

  chk_retlit_wreg: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_RETLIT |=> wreg_ff == $past(lit)) else $error("return literal not in w");
  chk_retlit_pc: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_RETLIT |=> ##1 program_counter_ff == $past(ret_addr_ff))
    else $error("program counter not loaded from stack");
  chk_retlit_two: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_RETLIT |=> state_ff == ST_RET2 ##1 state_ff == ST_IDLE)
    else $error("return not two cycles");
  chk_rotr_carry: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_ROT_R |=> carry_ff == $past(f_val[0]) && $stable(zero_ff))
    else $error("rotate right carry wrong");
  chk_rotl_carry: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_ROT_L |=> carry_ff == $past(f_val[7]) && $stable(digit_carry_flag_ff))
    else $error("rotate left carry wrong");
  chk_dest_file: assert property (@(posedge clk) disable iff (!rst_n)
    issue && res_valid && dest |=> $stable(wreg_ff)) else $error("w written with d=1");
  chk_sublit_res: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_SUB_LIT |=> wreg_ff == 8'($past(lit) - $past(wreg_ff)))
    else $error("literal subtract wrong");
  chk_subreg_w: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_SUB_REG && !dest |=> wreg_ff == 8'($past(f_val) - $past(wreg_ff)))
    else $error("register subtract wrong");
  chk_sub_borrow: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_SUB_LIT |=> carry_ff == ($past(lit) >= $past(wreg_ff)))
    else $error("subtract carry wrong");
  chk_sleep_flags: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_SLEEP |=> !power_down_flag_ff && timeout_flag_ff)
    else $error("sleep flags wrong");
  chk_sleep_wdt: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_SLEEP |=> watchdog_counter_ff == WATCHDOG_CLR && prescaler_ff == '0)
    else $error("watchdog not cleared");
  chk_sleep_halt: assert property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_SLEEP |=> osc_stop [*2]) else $error("sleep did not halt");

  cov_retlit: cover property (@(posedge clk) disable iff (!rst_n) issue && op == OP_RETLIT);
  cov_borrow: cover property (@(posedge clk) disable iff (!rst_n)
    issue && op == OP_SUB_REG && !sub_reg[9]);
  cov_wake: cover property (@(posedge clk) disable iff (!rst_n) sleeping ##1 !sleeping);
endmodule

// >>> dv/core_return_rotate_subtract_sleep_bench.sv
// self-checking bench for the return, rotate, subtract and sleep block
`timescale 1ns/100ps
module core_return_rotate_subtract_sleep_bench;
  import crs_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        osc_stop;
  int          failures;
  int          cmp_count;
  logic [31:0] rd_data;
  logic [1:0]  rsp;

  crs_core_exec #(.FILE_DEPTH(128), .STACK_DEPTH(16), .PRE_WIDTH(8)) crs_core_exec_inst (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_stop(osc_stop)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  // handshakes are judged between edges, where ready has settled for the coming edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    int   n;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    r    = 2'h3;
    b_hs = 1'b0;
    n    = 0;
    while (!b_hs && n < 50) begin
      @(negedge clk);
      aw_hs = (s_axi_awvalid & s_axi_awready) === 1'b1;
      w_hs  = (s_axi_wvalid & s_axi_wready) === 1'b1;
      b_hs  = (s_axi_bready & s_axi_bvalid) === 1'b1;
      r     = s_axi_bresp;
      @(posedge clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
      n++;
    end
    if (!b_hs) failures++;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs;
    logic r_hs;
    int   n;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_hs = 1'b0;
    n    = 0;
    while (!r_hs && n < 50) begin
      @(negedge clk);
      ar_hs = (s_axi_arvalid & s_axi_arready) === 1'b1;
      r_hs  = (s_axi_rready & s_axi_rvalid) === 1'b1;
      d     = s_axi_rdata;
      r     = s_axi_rresp;
      @(posedge clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
      n++;
    end
    if (!r_hs) failures++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    chk_resp(rsp, RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    axi_read(a, rd_data, rsp);
    chk_data(rd_data & mask, exp);
  endtask

  function automatic logic [31:0] instr(input crs_op_type op, input logic d, input logic [7:0] k);
    return {20'h0, op, d, k};
  endfunction

  // literal minus working register, then result and the three arithmetic flags
  task automatic sub_lit(input logic [7:0] k, input logic [7:0] w, input logic [7:0] res,
                         input logic [2:0] fl);
    wr(ADDR_WREG, {24'h0, w});
    wr(ADDR_INSTR, instr(OP_SUB_LIT, 1'b0, k));
    rd_chk(ADDR_WREG, 32'hFF, {24'h0, res});
    rd_chk(ADDR_STATUS, 32'h07, {29'h0, fl});
  endtask

  initial begin
    #200000;
    failures++;
    close_out();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_WREG, 32'hFF, 32'h0);
    rd_chk(ADDR_STATUS, 32'h7F, 32'h18);
    rd_chk(ADDR_PROG_CTR, 32'h1FFF, 32'h0);
    // unmapped place answers with an error and no data
    axi_write(8'h24, 32'h5A, rsp);
    chk_resp(rsp, RESP_SLVERR);
    axi_read(8'h24, rd_data, rsp);
    chk_resp(rsp, RESP_SLVERR);
    chk_data(rd_data, 32'h0);
    // three returns pop in reverse order of the pushes, the third wrapping to a reset stack entry
    wr(ADDR_STACK, 32'h0456);
    wr(ADDR_STACK, 32'h0789);
    wr(ADDR_INSTR, instr(OP_RETLIT, 1'b0, 8'hA5));
    rd_chk(ADDR_WREG, 32'hFF, 32'hA5);
    rd_chk(ADDR_PROG_CTR, 32'h1FFF, 32'h0789);
    wr(ADDR_INSTR, instr(OP_RETLIT, 1'b0, 8'h22));
    wr(ADDR_INSTR, instr(OP_RETLIT, 1'b0, 8'hFF));
    rd_chk(ADDR_WREG, 32'hFF, 32'hFF);
    rd_chk(ADDR_STATUS, 32'h7F, 32'h18);
    rd_chk(ADDR_PROG_CTR, 32'h1FFF, 32'h0000);
    // rotate left into the working register, then right into the file, digit carry and zero left alone
    wr(ADDR_STATUS, 32'h06);
    wr(ADDR_FILE_ADDR, 32'h05);
    wr(ADDR_FILE_DATA, 32'hE6);
    wr(ADDR_INSTR, instr(OP_ROT_L, 1'b0, 8'h05));
    rd_chk(ADDR_WREG, 32'hFF, 32'hCC);
    rd_chk(ADDR_STATUS, 32'h7F, 32'h1F);
    rd_chk(ADDR_FILE_DATA, 32'hFF, 32'hE6);
    wr(ADDR_INSTR, instr(OP_ROT_R, 1'b1, 8'h05));
    rd_chk(ADDR_FILE_DATA, 32'hFF, 32'hF3);
    rd_chk(ADDR_STATUS, 32'h7F, 32'h1E);
    rd_chk(ADDR_WREG, 32'hFF, 32'hCC);
    // top file address, carry out of bit zero, zero flag must stay clear
    wr(ADDR_STATUS, 32'h00);
    wr(ADDR_FILE_ADDR, 32'h7F);
    wr(ADDR_FILE_DATA, 32'h01);
    wr(ADDR_INSTR, instr(OP_ROT_R, 1'b1, 8'h7F));
    rd_chk(ADDR_FILE_DATA, 32'hFF, 32'h00);
    rd_chk(ADDR_STATUS, 32'h7F, 32'h19);
    sub_lit(8'h10, 8'h10, 8'h00, 3'h7);
    sub_lit(8'h05, 8'h06, 8'hFF, 3'h0);
    sub_lit(8'h20, 8'h01, 8'h1F, 3'h1);
    sub_lit(8'hFF, 8'h00, 8'hFF, 3'h3);
    // register subtract to the file, then to the working register
    wr(ADDR_FILE_ADDR, 32'h10);
    wr(ADDR_FILE_DATA, 32'h35);
    wr(ADDR_WREG, 32'h12);
    wr(ADDR_INSTR, instr(OP_SUB_REG, 1'b1, 8'h10));
    rd_chk(ADDR_FILE_DATA, 32'hFF, 32'h23);
    rd_chk(ADDR_WREG, 32'hFF, 32'h12);
    rd_chk(ADDR_STATUS, 32'h07, 32'h03);
    wr(ADDR_WREG, 32'h40);
    wr(ADDR_INSTR, instr(OP_SUB_REG, 1'b0, 8'h10));
    rd_chk(ADDR_WREG, 32'hFF, 32'hE3);
    rd_chk(ADDR_FILE_DATA, 32'hFF, 32'h23);
    rd_chk(ADDR_STATUS, 32'h07, 32'h02);
    // sleep after a long run, so the watchdog has moved before it is cleared
    repeat (600) @(posedge clk);
    axi_read(ADDR_WATCHDOG, rd_data, rsp);
    chk_data({31'h0, rd_data[7:0] != 8'h00}, 32'h1);
    wr(ADDR_INSTR, instr(OP_SLEEP, 1'b0, 8'h00));
    chk_data({31'h0, osc_stop}, 32'h1);
    rd_chk(ADDR_STATUS, 32'h58, 32'h50);
    axi_read(ADDR_WATCHDOG, rd_data, rsp);
    chk_data(rd_data & 32'hFF, 32'h0);
    chk_data({31'h0, rd_data[15:8] < 8'h10}, 32'h1);
    // a halted core ignores instructions
    wr(ADDR_INSTR, instr(OP_RETLIT, 1'b0, 8'h77));
    rd_chk(ADDR_WREG, 32'hFF, 32'hE3);
    wr(ADDR_WAKE, 32'h1);
    chk_data({31'h0, osc_stop}, 32'h0);
    rd_chk(ADDR_STATUS, 32'h40, 32'h00);
    close_out();
  end
endmodule
